// ### erbir_top.sv
// Banked peripheral register access and interrupt routing onto the core request lines
//
// What this block does
// - Bank bits plus address reach 4x8 registers
// - Three address bits select one of eight
// - Registers are 16 bits, steer peripherals
// - Speed-critical registers sit in bank 3
// - Four sources routed onto three core lines
// - Both timers ORed onto one line
// - Unmasked timer request loads vector flag: 0 second timer, 1 capture
// - Sync requests non-vectored, own core lines
// - Priority and per-source mask fields
`timescale 1ns/1ns
`default_nettype none

module erbir_top (
    input  wire logic                  clk,              // System clock, 125 MHz
    input  wire logic                  srst,             // Synchronous reset, active high
    // AXI4-Lite slave
    input  wire logic [7:0]            s_axi_awaddr,     // Write address
    input  wire logic                  s_axi_awvalid,    // Write address valid
    output logic                       s_axi_awready,    // Write address ready
    input  wire logic [31:0]           s_axi_wdata,      // Write data
    input  wire logic [3:0]            s_axi_wstrb,      // Write byte strobes
    input  wire logic                  s_axi_wvalid,     // Write data valid
    output logic                       s_axi_wready,     // Write data ready
    output logic [1:0]                 s_axi_bresp,      // Write response
    output logic                       s_axi_bvalid,     // Write response valid
    input  wire logic                  s_axi_bready,     // Write response ready
    input  wire logic [7:0]            s_axi_araddr,     // Read address
    input  wire logic                  s_axi_arvalid,    // Read address valid
    output logic                       s_axi_arready,    // Read address ready
    output logic [31:0]                s_axi_rdata,      // Read data
    output logic [1:0]                 s_axi_rresp,      // Read response
    output logic                       s_axi_rvalid,     // Read data valid
    input  wire logic                  s_axi_rready,     // Read data ready
    // Interrupt sources
    input  wire logic                  hsync_pin,        // Horizontal sync pin
    input  wire logic                  vsync_pin,        // Vertical sync pin
    input  wire logic                  tsec_evt,         // Second timer event pulse
    input  wire logic                  tcap_evt,         // Capture timer event pulse
    // Core side
    output logic [2:0]                 core_irq,         // Core request lines, one-hot winner
    output logic                       irq,              // Any unmasked pending source
    output logic [1:0]                 bank_sel,         // Current user bank bits
    // Peripheral register port
    output logic                       periph_req,       // One-cycle access strobe
    output erbir_pkg::erbir_preq_t     periph_cmd,       // Access location, kind and data
    input  wire logic [15:0]           periph_rdata      // Read data for periph_cmd.loc
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic                         aw_hold_q;
    logic [7:0]                   aw_addr_q;
    logic                         w_hold_q;
    logic [15:0]                  w_data_q;
    logic [1:0]                   w_strb_q;
    logic                         bvalid_q;
    logic [1:0]                   bresp_q;
    logic                         rd_busy_q;
    logic [7:0]                   rd_addr_q;
    logic                         rvalid_q;
    logic [1:0]                   rresp_q;
    logic [15:0]                  rdata_q;
    logic [1:0]                   bank_sel_q;
    logic [3:0]                   status_q;
    logic [3:0]                   status_d;
    logic [3:0]                   mask_q;
    logic [3:0]                   mask_d;
    logic [5:0]                   prio_q;
    logic [5:0]                   prio_d;
    logic                         vec_q;
    logic                         vec_d;
    logic [2:0]                   core_irq_q;
    logic                         irq_q;
    logic                         periph_req_q;
    erbir_pkg::erbir_preq_t       periph_cmd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel

    localparam logic [2:0] WIN_TOP = erbir_pkg::WIN_BASE_OFS[7:5];

    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready  = ~w_hold_q & ~bvalid_q;

    wire        aw_take  = s_axi_awvalid & s_axi_awready;
    wire        w_take   = s_axi_wvalid & s_axi_wready;
    wire        aw_have  = aw_hold_q | aw_take;
    wire        w_have   = w_hold_q | w_take;
    wire        wr_fire  = aw_have & w_have & ~bvalid_q;
    wire [7:0]  wr_addr  = aw_hold_q ? aw_addr_q : s_axi_awaddr;
    wire [15:0] wr_data  = w_hold_q ? w_data_q : s_axi_wdata[15:0];
    wire [1:0]  wr_strb  = w_hold_q ? w_strb_q : s_axi_wstrb[1:0];

    // three address bits pick the register
    wire [2:0]  wr_idx   = wr_addr[4:2];
    wire        wr_win   = (wr_addr[7:5] == WIN_TOP) && (wr_addr[1:0] == 2'h0);
    wire        wr_bsel  = (wr_addr == erbir_pkg::BANK_SEL_OFS);
    // bank bits extend the register address
    wire erbir_pkg::erbir_loc_t wr_loc = '{bank: bank_sel_q, idx: wr_idx};
    // interrupt registers grouped in bank 3
    wire        wr_irq   = wr_win && (wr_loc.bank == erbir_pkg::IRQ_BANK) && wr_idx[2];
    wire        wr_per   = wr_win && !wr_irq;
    wire        wr_mask  = wr_fire && wr_irq && (wr_idx == erbir_pkg::IRQ_MASK_IDX) && wr_strb[0];
    wire        wr_prio  = wr_fire && wr_irq && (wr_idx == erbir_pkg::IRQ_PRIO_IDX) && wr_strb[0];

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
        end else if (aw_take) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            w_hold_q <= 1'b0;
            w_data_q <= erbir_pkg::REG_ZERO;
            w_strb_q <= 2'h0;
        end else if (wr_fire) begin
            w_hold_q <= 1'b0;
        end else if (w_take) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= erbir_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_win || wr_bsel) ? erbir_pkg::RESP_OKAY : erbir_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel

    // Reads wait one cycle while a write uses the peripheral port
    assign s_axi_arready = ~rd_busy_q & ~rvalid_q & ~wr_fire;

    wire        ar_take  = s_axi_arvalid & s_axi_arready;
    wire [2:0]  ar_idx   = s_axi_araddr[4:2];
    wire        ar_win   = (s_axi_araddr[7:5] == WIN_TOP) && (s_axi_araddr[1:0] == 2'h0);
    wire        ar_irq   = ar_win && (bank_sel_q == erbir_pkg::IRQ_BANK) && ar_idx[2];

    wire [2:0]  rd_idx   = rd_addr_q[4:2];
    wire        rd_win   = (rd_addr_q[7:5] == WIN_TOP) && (rd_addr_q[1:0] == 2'h0);
    wire        rd_bsel  = (rd_addr_q == erbir_pkg::BANK_SEL_OFS);
    wire        rd_irq   = rd_win && (bank_sel_q == erbir_pkg::IRQ_BANK) && rd_idx[2];
    wire        rd_stat  = rd_busy_q && rd_irq && (rd_idx == erbir_pkg::IRQ_STAT_IDX);

    // vector flag readable for the core's branch
    wire [15:0] irq_rval = (rd_idx == erbir_pkg::IRQ_STAT_IDX) ? {12'h000, status_q} :
                           (rd_idx == erbir_pkg::IRQ_MASK_IDX) ? {12'h000, mask_q} :
                           (rd_idx == erbir_pkg::IRQ_PRIO_IDX) ? {10'h000, prio_q} :
                                                                 {15'h0000, vec_q};
    // 16-bit registers, upper bus bits read zero
    wire [15:0] rd_val   = rd_irq  ? irq_rval :
                           rd_win  ? periph_rdata :
                           rd_bsel ? {14'h0000, bank_sel_q} : erbir_pkg::REG_ZERO;

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_busy_q <= 1'b0;
            rd_addr_q <= 8'h00;
        end else if (ar_take) begin
            rd_busy_q <= 1'b1;
            rd_addr_q <= s_axi_araddr;
        end else begin
            rd_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rresp_q  <= erbir_pkg::RESP_OKAY;
            rdata_q  <= erbir_pkg::REG_ZERO;
        end else if (rd_busy_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= (rd_win || rd_bsel) ? erbir_pkg::RESP_OKAY : erbir_pkg::RESP_SLVERR;
            rdata_q  <= rd_val;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = {16'h0000, rdata_q};

    ////////////////////////////////////////////////////////////////////////////////
    // Bank select and peripheral port

    // bank bits stay until software rewrites them
    always_ff @(posedge clk) begin
        if (srst) begin
            bank_sel_q <= erbir_pkg::BANK_SEL_RST;
        end else if (wr_fire && wr_bsel && wr_strb[0]) begin
            bank_sel_q <= wr_data[1:0];
        end
    end

    assign bank_sel = bank_sel_q;

    // peripheral accesses forwarded with location and strobes
    wire periph_wr = wr_fire && wr_per;
    wire periph_rd = ar_take && ar_win && !ar_irq;
    wire erbir_pkg::erbir_preq_t periph_nxt = periph_wr ?
        erbir_pkg::erbir_preq_t'{we: 1'b1, loc: wr_loc, be: wr_strb, wdata: wr_data} :
        erbir_pkg::erbir_preq_t'{we: 1'b0, loc: '{bank: bank_sel_q, idx: ar_idx},
                                 be: 2'h0, wdata: erbir_pkg::REG_ZERO};

    always_ff @(posedge clk) begin
        if (srst) begin
            periph_req_q <= 1'b0;
            periph_cmd_q <= '0;
        end else begin
            periph_req_q <= periph_wr | periph_rd;
            periph_cmd_q <= (periph_wr | periph_rd) ? periph_nxt : periph_cmd_q;
        end
    end

    assign periph_req = periph_req_q;
    assign periph_cmd = periph_cmd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt sources

    logic hs_rise;
    logic vs_rise;

    erbir_pin_sync u_hs_sync (
        .clk  (clk),
        .srst (srst),
        .pin  (hsync_pin),
        .rise (hs_rise)
    );

    erbir_pin_sync u_vs_sync (
        .clk  (clk),
        .srst (srst),
        .pin  (vsync_pin),
        .rise (vs_rise)
    );

    wire [3:0] src_evt = {tcap_evt, tsec_evt, vs_rise, hs_rise};

    ////////////////////////////////////////////////////////////////////////////////
    // Status, mask, priority and vector registers

    // Read of status clears it; a new event in that cycle survives
    assign status_d = (status_q & ~{4{rd_stat}}) | src_evt;

    // per-source mask and per-line priority fields
    assign mask_d = wr_mask ? wr_data[3:0] : mask_q;
    assign prio_d = wr_prio ? wr_data[5:0] : prio_q;

    wire [3:0] live_evt = src_evt & ~mask_q;

    // masked timer leaves the vector alone
    assign vec_d = live_evt[erbir_pkg::SRC_TSEC] ? erbir_pkg::VEC_TSEC :
                   live_evt[erbir_pkg::SRC_TCAP] ? erbir_pkg::VEC_TCAP : vec_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= 4'h0;
            mask_q   <= erbir_pkg::IRQ_MASK_RST;
            prio_q   <= erbir_pkg::IRQ_PRIO_RST;
            vec_q    <= erbir_pkg::VEC_TSEC;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            prio_q   <= prio_d;
            vec_q    <= vec_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Routing onto the core request lines

    wire [3:0] live = status_q & ~mask_q;

    // sync sources each on their own line
    wire [2:0] line_pend = {live[erbir_pkg::SRC_TSEC] | live[erbir_pkg::SRC_TCAP],
                            live[erbir_pkg::SRC_VSYNC],
                            live[erbir_pkg::SRC_HSYNC]};

    wire [1:0] p0 = prio_q[1:0];
    wire [1:0] p1 = prio_q[3:2];
    wire [1:0] p2 = prio_q[5:4];

    // higher priority value wins, ties go to the lower line
    wire w0 = line_pend[0] && !(line_pend[1] && (p1 > p0)) && !(line_pend[2] && (p2 > p0));
    wire w1 = line_pend[1] && !(line_pend[0] && (p0 >= p1)) && !(line_pend[2] && (p2 > p1));
    wire w2 = line_pend[2] && !(line_pend[0] && (p0 >= p2)) && !(line_pend[1] && (p1 >= p2));

    always_ff @(posedge clk) begin
        if (srst) begin
            core_irq_q <= 3'h0;
            irq_q      <= 1'b0;
        end else begin
            core_irq_q <= {w2, w1, w0};
            irq_q      <= |line_pend;
        end
    end

    assign core_irq = core_irq_q;
    assign irq      = irq_q;

endmodule

`default_nettype wire

// ### erbir_pkg.sv
// Constants, register map and carrier types of the banked register and interrupt routing block
package erbir_pkg;

    // Software bus geometry
    localparam int unsigned AXI_ADDR_W = 8;
    localparam int unsigned AXI_DATA_W = 32;
    localparam int unsigned REG_W      = 16;

    // Banked space: four banks of eight registers
    localparam int unsigned BANK_W     = 2;
    localparam int unsigned IDX_W      = 3;
    localparam int unsigned NUM_BANKS  = 4;
    localparam int unsigned REGS_BANK  = 8;

    // Byte offsets on the software bus
    localparam logic [7:0] WIN_BASE_OFS = 8'h00;
    localparam logic [7:0] BANK_SEL_OFS = 8'h20;

    // Interrupt registers live in the speed-critical bank
    localparam logic [1:0] IRQ_BANK      = 2'h3;
    localparam logic [2:0] IRQ_STAT_IDX  = 3'h4;
    localparam logic [2:0] IRQ_MASK_IDX  = 3'h5;
    localparam logic [2:0] IRQ_PRIO_IDX  = 3'h6;
    localparam logic [2:0] IRQ_VEC_IDX   = 3'h7;

    // Interrupt sources: bit positions in status and mask
    localparam int unsigned NUM_SRC    = 4;
    localparam int unsigned SRC_HSYNC  = 0;
    localparam int unsigned SRC_VSYNC  = 1;
    localparam int unsigned SRC_TSEC   = 2;
    localparam int unsigned SRC_TCAP   = 3;

    // Core request lines and priority field positions
    localparam int unsigned NUM_LINES  = 3;
    localparam int unsigned LINE_HSYNC = 0;
    localparam int unsigned LINE_VSYNC = 1;
    localparam int unsigned LINE_TIMER = 2;
    localparam int unsigned PRIO_W     = 2;

    // Vector flag values
    localparam logic VEC_TSEC = 1'b0;
    localparam logic VEC_TCAP = 1'b1;

    // Values after reset
    localparam logic [1:0]  BANK_SEL_RST = 2'h0;
    localparam logic [3:0]  IRQ_MASK_RST = 4'hF;
    localparam logic [5:0]  IRQ_PRIO_RST = 6'h06;
    localparam logic [15:0] REG_ZERO     = 16'h0000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [IDX_W-1:0]  idx;
    } erbir_loc_t;

    typedef struct packed {
        logic              we;
        erbir_loc_t        loc;
        logic [1:0]        be;
        logic [REG_W-1:0]  wdata;
    } erbir_preq_t;

endpackage

// ### erbir_pin_sync.sv
// Pin synchroniser with rising-edge event for a sync input
`timescale 1ns/1ns
`default_nettype none

module erbir_pin_sync (
    input  wire logic clk,      // System clock
    input  wire logic srst,     // Synchronous reset, active high
    input  wire logic pin,      // Asynchronous pin level
    output logic      rise      // One-cycle pulse on an accepted rising edge
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic stable_q;
    logic rise_q;

    // Change is accepted only once stages two and three agree
    wire agree = (s2_q == s3_q);

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q     <= 1'b0;
            s2_q     <= 1'b0;
            s3_q     <= 1'b0;
            stable_q <= 1'b0;
            rise_q   <= 1'b0;
        end else begin
            s1_q     <= pin;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            stable_q <= agree ? s3_q : stable_q;
            rise_q   <= agree & s3_q & ~stable_q;
        end
    end

    assign rise = rise_q;

endmodule

`default_nettype wire

// ### erbir_sva.sv
// Port-level assertions for the banked register and interrupt routing block
`timescale 1ns/1ns
`default_nettype none

module erbir_sva (
    input wire logic                   clk,           // Clock
    input wire logic                   srst,          // Sync reset
    input wire logic                   s_axi_awvalid, // AW valid
    input wire logic                   s_axi_awready, // AW ready
    input wire logic                   s_axi_wvalid,  // W valid
    input wire logic                   s_axi_wready,  // W ready
    input wire logic [1:0]             s_axi_bresp,   // B response
    input wire logic                   s_axi_bvalid,  // B valid
    input wire logic                   s_axi_bready,  // B ready
    input wire logic                   s_axi_arvalid, // AR valid
    input wire logic                   s_axi_arready, // AR ready
    input wire logic [31:0]            s_axi_rdata,   // R data
    input wire logic                   s_axi_rvalid,  // R valid
    input wire logic                   s_axi_rready,  // R ready
    input wire logic [2:0]             core_irq,      // Core lines
    input wire logic                   irq,           // Any request
    input wire logic [1:0]             bank_sel,      // Bank bits
    input wire logic                   periph_req,    // Peripheral strobe
    input wire erbir_pkg::erbir_preq_t periph_cmd     // Peripheral command
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_onehot; $onehot0(core_irq); endproperty
    a_onehot: assert property (p_onehot) else $error("core_irq has several lines");
    property p_irq_core; irq == (core_irq != 3'h0); endproperty
    a_irq_core: assert property (p_irq_core) else $error("irq and core_irq disagree");
    property p_no_irq_regs; periph_req |-> !(periph_cmd.loc.bank == erbir_pkg::IRQ_BANK && periph_cmd.loc.idx[2]);
    endproperty
    a_no_irq_regs: assert property (p_no_irq_regs) else $error("interrupt register leaked to port");
    property p_bank; periph_req |-> periph_cmd.loc.bank == bank_sel; endproperty
    a_bank: assert property (p_bank) else $error("access bank differs from bank bits");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_wans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
    a_wans: assert property (p_wans) else $error("write response late");
    property p_rans; s_axi_arvalid && s_axi_arready |-> ##1 !s_axi_rvalid ##1 s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read response timing wrong");
    property p_rupper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_rupper: assert property (p_rupper) else $error("upper read half not zero");
    property p_awref; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_awref: assert property (p_awref) else $error("address taken during response");

    c_timer: cover property (irq && core_irq[2]);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == erbir_pkg::RESP_SLVERR);
    c_pwrite: cover property (periph_req && periph_cmd.we);
endmodule

`default_nettype wire

// ### erbir_periph_model.sv
// Behavioural peripheral register file behind the peripheral port
`timescale 1ns/1ns
`default_nettype none

module erbir_periph_model (
    input  wire logic                   clk,          // Clock
    input  wire logic                   periph_req,   // Access strobe
    input  wire erbir_pkg::erbir_preq_t periph_cmd,   // Access command
    output logic [15:0]                 periph_rdata  // Read data
);
    logic [15:0] mem [0:31];
    wire  [4:0]  sel = periph_cmd.loc;

    always_ff @(posedge clk) begin
        if (periph_req && periph_cmd.we) begin
            if (periph_cmd.be[0]) mem[sel][7:0] <= periph_cmd.wdata[7:0];
            if (periph_cmd.be[1]) mem[sel][15:8] <= periph_cmd.wdata[15:8];
        end
    end
    // Inverted data outside a read so a stale sample shows
    assign periph_rdata = (periph_req && !periph_cmd.we) ? mem[sel] : ~mem[sel];
endmodule

`default_nettype wire

// ### ext_reg_bank_and_irq_routing_tb_top.sv
// Self-checking bench for the banked register and interrupt routing block
`timescale 1ns/1ns
`default_nettype none

module ext_reg_bank_and_irq_routing_tb_top;
    logic                   clk = 1'h0;
    logic                   srst = 1'h1;
    logic [7:0]             s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]            s_axi_wdata = 32'h0000_0000;
    logic [3:0]             s_axi_wstrb = 4'hF;
    logic                   s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic                   s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic                   hsync_pin = 1'h0, vsync_pin = 1'h0, tsec_evt = 1'h0, tcap_evt = 1'h0;
    wire                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]             s_axi_bresp, s_axi_rresp, bank_sel;
    wire  [31:0]            s_axi_rdata;
    wire  [2:0]             core_irq;
    wire                    irq, periph_req;
    wire  [15:0]            periph_rdata;
    wire  erbir_pkg::erbir_preq_t periph_cmd;
    int                     fail_count = 0, n_tests = 0;
    logic [15:0]            pv [3] = '{16'h0006, 16'h000C, 16'h0000};
    logic [2:0]             pe [3] = '{3'h1, 3'h2, 3'h1};

    erbir_top uut (.*);
    erbir_periph_model u_periph (.*);

    initial forever #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    function automatic logic [7:0] ra(input logic [2:0] i);
        return {3'h0, i, 2'h0};
    endfunction

    task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = erbir_pkg::RESP_OKAY);
        logic [1:0] r;
        axi_wr(a, d, r);
        check("bresp", 32'(er), 32'(r));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = erbir_pkg::RESP_OKAY);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        check("rresp", 32'(er), 32'(s_axi_rresp));
        check("rdata", e, s_axi_rdata);
        s_axi_rready <= 1'h0;
    endtask

    task automatic clr(input logic [31:0] es);
        rd(ra(erbir_pkg::IRQ_STAT_IDX), es);
        repeat (3) @(posedge clk);
        check("irq_after_clear", 32'h0000_0000, 32'(irq));
    endtask

    task automatic pcase(input logic h, input logic v, input logic [2:0] ec, input logic [31:0] es);
        hsync_pin <= h;
        vsync_pin <= v;
        repeat (10) @(posedge clk);
        hsync_pin <= 1'h0;
        vsync_pin <= 1'h0;
        check("core_irq", 32'(ec), 32'(core_irq));
        check("irq", 32'(ec != 3'h0), 32'(irq));
        clr(es);
    endtask

    task automatic tcase(input logic s, input logic c, input logic [2:0] ec, input logic [31:0] ev, input logic [31:0] es);
        tsec_evt <= s;
        tcap_evt <= c;
        @(posedge clk);
        tsec_evt <= 1'h0;
        tcap_evt <= 1'h0;
        repeat (3) @(posedge clk);
        check("core_irq", 32'(ec), 32'(core_irq));
        rd(ra(erbir_pkg::IRQ_VEC_IDX), ev);
        clr(es);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'h0;
        rd(erbir_pkg::BANK_SEL_OFS, 32'(erbir_pkg::BANK_SEL_RST));
        for (int b = 0; b < 4; b++) begin
            wr(erbir_pkg::BANK_SEL_OFS, 16'(b));
            for (int i = 0; i < 8; i++) if (b < 3 || i < 4) wr(ra(3'(i)), {8'hA5, 2'(b), 3'h0, 3'(i)});
        end
        for (int b = 0; b < 4; b++) begin
            wr(erbir_pkg::BANK_SEL_OFS, 16'(b));
            check("bank_sel", 32'(b), 32'(bank_sel));
            for (int i = 0; i < 8; i++) if (b < 3 || i < 4) rd(ra(3'(i)), {16'h0000, 8'hA5, 2'(b), 3'h0, 3'(i)});
        end
        rd(8'h24, 32'h0000_0000, erbir_pkg::RESP_SLVERR);
        wr(8'h02, 16'h0001, erbir_pkg::RESP_SLVERR);
        rd(ra(erbir_pkg::IRQ_MASK_IDX), 32'(erbir_pkg::IRQ_MASK_RST));
        rd(ra(erbir_pkg::IRQ_PRIO_IDX), 32'(erbir_pkg::IRQ_PRIO_RST));
        wr(ra(erbir_pkg::IRQ_STAT_IDX), 16'h000F);
        rd(ra(erbir_pkg::IRQ_STAT_IDX), 32'h0000_0000);
        pcase(1'h1, 1'h0, 3'h0, 32'h0000_0001);
        wr(ra(erbir_pkg::IRQ_MASK_IDX), 16'h0000);
        pcase(1'h1, 1'h0, 3'h1, 32'h0000_0001);
        pcase(1'h0, 1'h1, 3'h2, 32'h0000_0002);
        tcase(1'h0, 1'h1, 3'h4, 32'h0000_0001, 32'h0000_0008);
        tcase(1'h1, 1'h1, 3'h4, 32'h0000_0000, 32'h0000_000C);
        tcase(1'h0, 1'h1, 3'h4, 32'h0000_0001, 32'h0000_0008);
        wr(ra(erbir_pkg::IRQ_MASK_IDX), 16'h0004);
        tcase(1'h1, 1'h0, 3'h0, 32'h0000_0001, 32'h0000_0004);
        wr(ra(erbir_pkg::IRQ_MASK_IDX), 16'h0000);
        for (int k = 0; k < 3; k++) begin
            wr(ra(erbir_pkg::IRQ_PRIO_IDX), pv[k]);
            pcase(1'h1, 1'h1, pe[k], 32'h0000_0003);
        end
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule

bind erbir_top erbir_sva u_sva (.*);

`default_nettype wire
